/* logic/csm_regs.vh */
// register map, field positions, reset values and timing counts of the mode control block
// assumes a 32-bit apb slave, one aligned word per register
`ifndef CSM_REGS_VH
`define CSM_REGS_VH
// byte addresses
`define CSM_ADDR_MODE_CONTROL  12'h000
`define CSM_ADDR_MODE_CONFIG   12'h004
`define CSM_ADDR_RX_FLAGS      12'h008
`define CSM_ADDR_RX_IRQ_EN     12'h00c
`define CSM_ADDR_TX_FLAGS      12'h010
`define CSM_ADDR_TX_IRQ_EN     12'h014
`define CSM_ADDR_TX_ABORT_REQ  12'h018
`define CSM_ADDR_TX_ABORT_ACK  12'h01c
`define CSM_ADDR_TX_BUF_SEL    12'h020
`define CSM_ADDR_BIT_TIMING_A  12'h024
`define CSM_ADDR_BIT_TIMING_B  12'h028
`define CSM_ADDR_ACC_CONTROL   12'h02c
`define CSM_ADDR_ACC_CODE0     12'h040
`define CSM_ADDR_ACC_MASK0     12'h060
`define CSM_ADDR_ERR_COUNT     12'h080
// mode_control fields
`define CSM_INIT_REQUEST   0
`define CSM_SLEEP_REQUEST  1
`define CSM_STOP_IN_WAIT   5
`define CSM_WAKEUP_ENABLE  2
// mode_config_status fields
`define CSM_INIT_ACK   0
`define CSM_SLEEP_ACK  1
// rx_flags / rx_irq_enables fields
`define CSM_WAKEUP_IRQ_FLAG  7
`define CSM_WAKEUP_IRQ_EN    7
// reset values
`define CSM_RST_MODE_CONTROL 8'h01
`define CSM_RST_MODE_CONFIG  8'h01
`define CSM_RST_TX_FLAGS     8'h07
`define CSM_RST_TX_BUF_SEL   8'h00
// resync counts
`define CSM_IDLE_BITS     11
`define CSM_BUSOFF_REPS   128
`endif

/* logic/csm_sync.v */
// two-flip-flop synchroniser for one level from outside the clock domain
// assumes pclk and presetn of the register side
module csm_sync #(
	parameter RESET_VAL = 1'b1
) (
	// clock and reset
	input  wire pclk,
	input  wire presetn,
	input  wire clk_en,
	// level
	input  wire din,
	output reg  dout
);
	reg meta;
	// first stage feeds only the second one
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= RESET_VAL;
			dout <= RESET_VAL;
		end else if (clk_en) begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

/* logic/csm_resync.v */
// counts runs of recessive bits to decide when the bus may be joined again
// assumes one bit_tick per nominal bit time and a synchronised rx level
`include "csm_regs.vh"
module csm_resync #(
	parameter RUN_BITS = `CSM_IDLE_BITS,
	parameter REPS     = `CSM_BUSOFF_REPS
) (
	// clock and reset
	input  wire pclk,
	input  wire presetn,
	input  wire clk_en,
	// control
	input  wire start,
	input  wire bus_off,
	input  wire bit_tick,
	input  wire rx_level,
	// status
	output reg  done
);
	reg [7:0] run_cnt;
	reg [7:0] rep_cnt;
	reg       active;
	wire run_full = (run_cnt == RUN_BITS[7:0] - 8'h01);
	wire reps_ok  = !bus_off || (rep_cnt == REPS[7:0] - 8'h01);
	// a dominant bit restarts the run; each full run counts one repetition
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_cnt <= 8'h00;
			rep_cnt <= 8'h00;
			active  <= 1'b0;
			done    <= 1'b0;
		end else if (clk_en) begin
			done <= 1'b0;
			if (start) begin
				run_cnt <= 8'h00;
				rep_cnt <= 8'h00;
				active  <= 1'b1;
			end else if (active && bit_tick) begin
				if (!rx_level)
					run_cnt <= 8'h00;
				else if (run_full) begin
					run_cnt <= 8'h00;
					if (reps_ok) begin
						active <= 1'b0;
						done   <= 1'b1;
					end else
						rep_cnt <= rep_cnt + 8'h01;
				end else
					run_cnt <= run_cnt + 8'h01;
			end
		end
	end
endmodule

/* logic/csm_mode_ctrl.v */
// sleep and initialization mode control of a can controller, with its apb register file
// assumes the protocol engine supplies busy, bit tick, bus-off and error counters
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`include "csm_regs.vh"
module csm_mode_ctrl #(
	parameter RUN_BITS = `CSM_IDLE_BITS,
	parameter REPS     = `CSM_BUSOFF_REPS
) (
	// clock, reset, enable
	input  wire        pclk,
	input  wire        presetn,
	input  wire        clk_en,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// protocol engine side
	input  wire        rx_busy,
	input  wire        tx_pending,
	input  wire        bit_tick,
	input  wire        bus_off,
	input  wire [7:0]  rx_err_count,
	input  wire [7:0]  tx_err_count,
	input  wire [3:0]  state_bits,
	output reg         abort_xfer,
	output reg         bus_synced,
	// processor low-power state
	input  wire        cpu_stop,
	input  wire        cpu_wait,
	// can pins
	input  wire        bus_rx_pin,
	output reg         bus_tx_pin,
	input  wire        engine_tx,
	output reg         wakeup_irq
);
	// control registers
	reg        init_request;
	reg        sleep_request;
	reg        init_ack;
	reg        sleep_ack;
	reg [7:0]  mode_control;
	reg [7:0]  mode_config_status;
	reg [7:0]  rx_flags;
	reg [7:0]  rx_irq_enables;
	reg [7:0]  tx_flags;
	reg [7:0]  tx_irq_enables;
	reg [7:0]  tx_abort_request;
	reg [7:0]  tx_abort_ack;
	reg [7:0]  tx_buffer_select;
	reg [7:0]  bit_timing_a;
	reg [7:0]  bit_timing_b;
	reg [7:0]  acceptance_control;
	reg [7:0]  acceptance_code [0:7];
	reg [7:0]  acceptance_mask [0:7];
	reg        rx_prev;
	reg [31:0] next_prdata;
	integer    i;

	wire rx_sync;
	wire resync_done;
	wire wr_access  = psel && penable && pwrite && pready;
	wire rd_setup   = psel && !penable && !pwrite;
	wire sleeping   = sleep_request && sleep_ack;
	wire init_mode  = init_request && init_ack;
	wire wakeup_en  = mode_control[`CSM_WAKEUP_ENABLE];
	wire bus_active = rx_prev && !rx_sync; // falling edge on the bus
	wire [7:0] wd   = pwdata[7:0];
	// codes and masks each fill one 32-byte slot, word index in paddr[4:2]
	wire acc_code_hit = ({paddr[11:5], 5'h00} == `CSM_ADDR_ACC_CODE0);
	wire acc_mask_hit = ({paddr[11:5], 5'h00} == `CSM_ADDR_ACC_MASK0);
	// a write that sets init_request acts on the pin at its own edge, not one later
	wire init_set   = wr_access && paddr == `CSM_ADDR_MODE_CONTROL && wd[`CSM_INIT_REQUEST];
	// reset image of mode_control, sliced when init entry restores its upper bits
	wire [7:0] ctl_rst_val = `CSM_RST_MODE_CONTROL;

	// clk_en low freezes every flop here; software must keep the bus idle meanwhile
	// bus input is asynchronous to pclk
	csm_sync #(
		.RESET_VAL(1'b1)
	) u_rx_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.clk_en  (clk_en),
		.din     (bus_rx_pin),
		.dout    (rx_sync)
	);

	// resync starts on the very write that leaves init mode; a refused clear starts nothing
	csm_resync #(
		.RUN_BITS(RUN_BITS),
		.REPS    (REPS)
	) u_resync (
		.pclk     (pclk),
		.presetn  (presetn),
		.clk_en   (clk_en),
		.start    (wr_access && paddr == `CSM_ADDR_MODE_CONTROL && init_mode
		           && !wd[`CSM_INIT_REQUEST]),
		.bus_off  (bus_off),
		.bit_tick (bit_tick),
		.rx_level (rx_sync),
		.done     (resync_done)
	);

	// read mux; unmapped addresses read zero
	always @* begin
		next_prdata = 32'h0000_0000;
		case (paddr)
		`CSM_ADDR_MODE_CONTROL: next_prdata = {24'h0, mode_control[7:2],
		                                       sleep_request, init_request};
		`CSM_ADDR_MODE_CONFIG:  next_prdata = {24'h0, mode_config_status[7:2],
		                                       sleep_ack, init_ack};
		`CSM_ADDR_RX_FLAGS:     next_prdata = {24'h0, rx_flags[7:6],
		                                       state_bits, rx_flags[1:0]};
		`CSM_ADDR_RX_IRQ_EN:    next_prdata = {24'h0, rx_irq_enables};
		`CSM_ADDR_TX_FLAGS:     next_prdata = {24'h0, tx_flags};
		`CSM_ADDR_TX_IRQ_EN:    next_prdata = {24'h0, tx_irq_enables};
		`CSM_ADDR_TX_ABORT_REQ: next_prdata = {24'h0, tx_abort_request};
		`CSM_ADDR_TX_ABORT_ACK: next_prdata = {24'h0, tx_abort_ack};
		`CSM_ADDR_TX_BUF_SEL:   next_prdata = {24'h0, tx_buffer_select};
		`CSM_ADDR_BIT_TIMING_A: next_prdata = {24'h0, bit_timing_a};
		`CSM_ADDR_BIT_TIMING_B: next_prdata = {24'h0, bit_timing_b};
		`CSM_ADDR_ACC_CONTROL:  next_prdata = {24'h0, acceptance_control};
		`CSM_ADDR_ERR_COUNT:    next_prdata = {16'h0, tx_err_count, rx_err_count};
		default: begin
			if (acc_code_hit)
				next_prdata = {24'h0, acceptance_code[paddr[4:2]]};
			else if (acc_mask_hit)
				next_prdata = {24'h0, acceptance_mask[paddr[4:2]]};
		end
		endcase
	end

	// apb handshake: no wait state, read data captured in setup
	// a write lands at the access edge, where pready already stands high
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (clk_en) begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			if (rd_setup)
				prdata <= next_prdata;
		end
	end

	// request bits and the handshake acknowledges
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_request  <= 1'b1;
			sleep_request <= 1'b0;
			init_ack      <= 1'b1;
			sleep_ack     <= 1'b0;
			mode_control  <= `CSM_RST_MODE_CONTROL;
			mode_config_status <= `CSM_RST_MODE_CONFIG;
		end else if (clk_en) begin
			// init_ack moves only by the handshake; sleep_ack is also cleared by a write or a wake-up
			if (init_request && !init_ack)
				init_ack <= 1'b1;
			else if (!init_request)
				init_ack <= 1'b0;
			// sleep waits for a quiet bus and is never granted while init is requested
			if (sleep_request && !sleep_ack && !rx_busy && !tx_pending && !init_request)
				sleep_ack <= 1'b1;
			if (wr_access && paddr == `CSM_ADDR_MODE_CONTROL) begin
				mode_control[7:2] <= wd[7:2];
				if (wd[`CSM_INIT_REQUEST])
					init_request <= 1'b1;
				else if (init_mode)
					init_request <= 1'b0;
				if (wd[`CSM_SLEEP_REQUEST]) begin
					if (!rx_flags[`CSM_WAKEUP_IRQ_FLAG] || sleep_request)
						sleep_request <= 1'b1;
				end else if (sleeping) begin
					sleep_request <= 1'b0;
					sleep_ack     <= 1'b0;
				end
			end
			if (wr_access && paddr == `CSM_ADDR_MODE_CONFIG && init_mode)
				mode_config_status[7:2] <= wd[7:2];
			if (sleeping && wakeup_en && bus_active) begin
				sleep_request <= 1'b0;
				sleep_ack     <= 1'b0;
			end
			// on entering init keep wake-up enable and the request bits, reset bits 7:3
			if (init_request && !init_ack)
				mode_control[7:3] <= ctl_rst_val[7:3];
		end
	end

	// status and enable registers return to their reset values on init entry (tx_flags to 07)
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_flags         <= 8'h00;
			rx_irq_enables   <= 8'h00;
			tx_flags         <= `CSM_RST_TX_FLAGS;
			tx_irq_enables   <= 8'h00;
			tx_abort_request <= 8'h00;
			tx_abort_ack     <= 8'h00;
			tx_buffer_select <= `CSM_RST_TX_BUF_SEL;
			rx_prev          <= 1'b1;
		end else if (clk_en) begin
			rx_prev <= rx_sync;
			if (init_request && !init_ack) begin
				rx_flags         <= 8'h00;
				rx_irq_enables   <= 8'h00;
				tx_flags         <= `CSM_RST_TX_FLAGS;
				tx_irq_enables   <= 8'h00;
				tx_abort_request <= 8'h00;
				tx_abort_ack     <= 8'h00;
				tx_buffer_select <= `CSM_RST_TX_BUF_SEL;
			end else begin
				if (wr_access && paddr == `CSM_ADDR_RX_IRQ_EN)
					rx_irq_enables <= wd;
				if (wr_access && paddr == `CSM_ADDR_TX_IRQ_EN)
					tx_irq_enables <= wd;
				if (wr_access && paddr == `CSM_ADDR_TX_ABORT_REQ)
					tx_abort_request <= wd;
				if (wr_access && paddr == `CSM_ADDR_TX_BUF_SEL)
					tx_buffer_select <= wd;
				// write one to clear; a wake-up in the same cycle wins
				if (wr_access && paddr == `CSM_ADDR_RX_FLAGS)
					rx_flags <= rx_flags & ~wd;
				if (sleeping && bus_active)
					rx_flags[`CSM_WAKEUP_IRQ_FLAG] <= 1'b1;
			end
		end
	end

	// configuration registers, locked outside init mode
	// writes outside init mode are dropped without an error response
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_timing_a       <= 8'h00;
			bit_timing_b       <= 8'h00;
			acceptance_control <= 8'h00;
			for (i = 0; i < 8; i = i + 1) begin
				acceptance_code[i] <= 8'h00;
				acceptance_mask[i] <= 8'h00;
			end
		end else if (clk_en && wr_access && init_mode) begin
			if (paddr == `CSM_ADDR_BIT_TIMING_A)
				bit_timing_a <= wd;
			if (paddr == `CSM_ADDR_BIT_TIMING_B)
				bit_timing_b <= wd;
			if (paddr == `CSM_ADDR_ACC_CONTROL)
				acceptance_control <= wd;
			if (acc_code_hit)
				acceptance_code[paddr[4:2]] <= wd;
			if (acc_mask_hit)
				acceptance_mask[paddr[4:2]] <= wd;
		end
	end

	// pin and engine control; requests act the cycle they are written
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_tx_pin <= 1'b1;
			abort_xfer <= 1'b1;
			bus_synced <= 1'b0;
			wakeup_irq <= 1'b0;
		end else if (clk_en) begin
			wakeup_irq <= rx_flags[`CSM_WAKEUP_IRQ_FLAG] && rx_irq_enables[`CSM_WAKEUP_IRQ_EN];
			// recessive on init request, on cpu stop, or on cpu wait while stop-in-wait is set
			// the pin does not wait for init_ack, so a frame in flight is cut at once
			if (init_request || init_set || cpu_stop
			    || (cpu_wait && mode_control[`CSM_STOP_IN_WAIT]))
				bus_tx_pin <= 1'b1;
			else
				bus_tx_pin <= engine_tx;
			abort_xfer <= init_request || init_set;
			if (init_request || init_set)
				bus_synced <= 1'b0;
			else if (resync_done)
				bus_synced <= 1'b1;
		end
	end
endmodule

/* testbench/csm_mode_chk_checker.sv */
// port assertions for the can mode control block
// assumes one pclk domain and the design's own count parameters
module csm_mode_chk #(
	parameter RUN_BITS = 11,
	parameter REPS     = 128
) (
	// clock and reset
	input wire        pclk,
	input wire        presetn,
	// apb
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire        pready,
	// engine, cpu state and pins
	input wire        bit_tick,
	input wire        bus_off,
	input wire        cpu_stop,
	input wire        abort_xfer,
	input wire        bus_synced,
	input wire        bus_tx_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [15:0] ticks;
	wire         init_wr = psel && penable && pwrite && paddr == 12'h000 && pwdata[0];
	// bit times since init was left; the last abort edge already counts its tick,
	// as the resync counter runs from the clearing write on
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ticks <= 16'h0000;
		else if (abort_xfer)
			ticks <= {15'h0000, bit_tick};
		else if (bit_tick && ticks != 16'hffff)
			ticks <= ticks + 16'h0001;
	end
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready in access cycle");
	property p_ready_once; pready |=> !pready; endproperty
	a_ready_once: assert property (p_ready_once) else $error("ready held too long");
	property p_abort; init_wr |=> abort_xfer; endproperty
	a_abort: assert property (p_abort) else $error("no abort on init");
	property p_sync_drop; abort_xfer ##1 abort_xfer |-> !bus_synced; endproperty
	a_sync_drop: assert property (p_sync_drop) else $error("sync kept in init");
	property p_tx_init; init_wr |=> bus_tx_pin; endproperty
	a_tx_init: assert property (p_tx_init) else $error("tx not recessive");
	property p_tx_abort; abort_xfer |-> bus_tx_pin; endproperty
	a_tx_abort: assert property (p_tx_abort) else $error("tx driven in init");
	property p_tx_stop; cpu_stop ##1 cpu_stop |-> bus_tx_pin; endproperty
	a_tx_stop: assert property (p_tx_stop) else $error("tx driven in stop");
	property p_resync; $rose(bus_synced) |-> ticks >= RUN_BITS; endproperty
	a_resync: assert property (p_resync) else $error("resync too early");
	property p_busoff; $rose(bus_synced) && bus_off |-> ticks >= RUN_BITS * REPS; endproperty
	a_busoff: assert property (p_busoff) else $error("bus-off resync early");
endmodule
bind csm_mode_ctrl csm_mode_chk #(.RUN_BITS(RUN_BITS), .REPS(REPS)) chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .bit_tick(bit_tick),
	.bus_off(bus_off), .cpu_stop(cpu_stop), .abort_xfer(abort_xfer),
	.bus_synced(bus_synced), .bus_tx_pin(bus_tx_pin));

/* testbench/csm_bus_model.sv */
// behavioural can bus and engine bit source
// assumes the bench asks for a wake burst by wake_cmd
module csm_bus_model (
	// clock and command
	input  wire  pclk,
	input  wire  presetn,
	input  wire  wake_cmd,
	// bus side
	output logic bit_tick,
	output logic bus_rx_pin,
	output logic engine_tx
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] phase;
	logic [2:0] low_left;
	// a bit time of four clocks keeps the resync waits short
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase    <= 2'h0;
			low_left <= 3'h0;
		end else begin
			phase <= phase + 2'h1;
			if (wake_cmd)
				low_left <= 3'h6;
			else if (low_left != 3'h0)
				low_left <= low_left - 3'h1;
		end
	end
	assign bit_tick   = (phase == 2'h3);
	// dominant burst on request, otherwise the bus idles recessive
	assign bus_rx_pin = (low_left == 3'h0);
	// engine output toggles every two clocks, twice per bit time
	assign engine_tx  = phase[1];
endmodule

/* testbench/csm_mode_ctrl_tb.sv */
// self-checking bench for the can mode control block
// assumes the bus model stands in for the wires and the bit clock
module csm_mode_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        rx_busy = 0, tx_pending = 0, bus_off = 0, cpu_stop = 0, wake_cmd = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        clk_en = 1, cpu_wait = 0, slv_err = 0;
	wire  [31:0] prdata;
	wire         pready, pslverr, bit_tick, abort_xfer, bus_synced, bus_rx_pin;
	wire         bus_tx_pin, engine_tx, wakeup_irq;
	int          fails = 0, total_checks = 0, cycles = 0;
	csm_mode_ctrl #(.RUN_BITS(3), .REPS(2)) dut_u (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_busy(rx_busy), .tx_pending(tx_pending), .bit_tick(bit_tick),
		.bus_off(bus_off), .rx_err_count(8'h5c), .tx_err_count(8'h5c), .state_bits(4'ha),
		.abort_xfer(abort_xfer), .bus_synced(bus_synced), .cpu_stop(cpu_stop),
		.cpu_wait(cpu_wait), .bus_rx_pin(bus_rx_pin), .bus_tx_pin(bus_tx_pin),
		.engine_tx(engine_tx), .wakeup_irq(wakeup_irq));
	csm_bus_model bus_u (.pclk(pclk), .presetn(presetn), .wake_cmd(wake_cmd),
		.bit_tick(bit_tick), .bus_rx_pin(bus_rx_pin), .engine_tx(engine_tx));
	initial forever #5 pclk = ~pclk;
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// one apb transfer; the idle cycle after it keeps drivers from double assignment
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		slv_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk($sformatf("reg %h", a), e, q);
	endtask
	// pins are looked at mid-cycle, where they have settled
	task automatic pin(input string n, input logic e, input logic g);
		@(negedge pclk);
		chk(n, {31'h0, e}, {31'h0, g});
		@(posedge pclk);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// cut a hang short
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			print_verdict;
		end
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rc(12'h000, 32'h01);
		rc(12'h004, 32'h01);
		rc(12'h010, 32'h07);
		pin("tx pin", 1'b1, bus_tx_pin);
		wr(12'h024, 32'h5a);
		rc(12'h024, 32'h5a);
		wr(12'h044, 32'h33);
		rc(12'h044, 32'h33);
		wr(12'h004, 32'h00);
		rc(12'h004, 32'h01);
		rc(12'h080, 32'h5c5c);
		$display("test init_mode done");
		wr(12'h000, 32'h00);
		rc(12'h004, 32'h00);
		for (int i = 0; i < 200 && bus_synced !== 1'b1; i++) @(posedge pclk);
		pin("synced", 1'b1, bus_synced);
		rc(12'h080, 32'h5c5c);
		wr(12'h024, 32'hff);
		chk("slverr", 32'h0, {31'h0, slv_err});
		rc(12'h024, 32'h5a);
		wr(12'h064, 32'h11);
		rc(12'h064, 32'h00);
		$display("test init_exit done");
		rx_busy <= 1'b1;
		wr(12'h000, 32'h02);
		rc(12'h004, 32'h00);
		wr(12'h000, 32'h00);
		rc(12'h000, 32'h02);
		rx_busy <= 1'b0;
		tx_pending <= 1'b1;
		rc(12'h004, 32'h00);
		tx_pending <= 1'b0;
		@(posedge pclk);
		rc(12'h004, 32'h02);
		wr(12'h00c, 32'h80);
		wr(12'h000, 32'h06);
		wake_cmd <= 1'b1;
		@(posedge pclk);
		wake_cmd <= 1'b0;
		for (int i = 0; i < 50 && wakeup_irq !== 1'b1; i++) @(posedge pclk);
		pin("wake irq", 1'b1, wakeup_irq);
		rc(12'h000, 32'h04);
		rc(12'h004, 32'h00);
		rc(12'h008, 32'ha8);
		wr(12'h000, 32'h06);
		rc(12'h000, 32'h04);
		wr(12'h008, 32'h80);
		rc(12'h008, 32'h28);
		$display("test sleep_wake done");
		wr(12'h000, 32'h06);
		rc(12'h004, 32'h02);
		wr(12'h000, 32'h04);
		rc(12'h004, 32'h00);
		rc(12'h000, 32'h04);
		wr(12'h014, 32'h05);
		wr(12'h018, 32'h0f);
		wr(12'h020, 32'h03);
		wr(12'h000, 32'h06);
		bus_off <= 1'b1;
		wr(12'h000, 32'h07);
		pin("tx pin", 1'b1, bus_tx_pin);
		pin("abort", 1'b1, abort_xfer);
		rc(12'h000, 32'h07);
		rc(12'h00c, 32'h00);
		rc(12'h010, 32'h07);
		rc(12'h014, 32'h00);
		rc(12'h020, 32'h00);
		rc(12'h018, 32'h00);
		rc(12'h008, 32'h28);
		wr(12'h000, 32'h00);
		for (int i = 0; i < 400 && bus_synced !== 1'b1; i++) @(posedge pclk);
		pin("synced", 1'b1, bus_synced);
		bus_off <= 1'b0;
		$display("test init_from_sleep done");
		cpu_stop <= 1'b1;
		repeat (2) @(posedge pclk);
		repeat (4) pin("tx pin", 1'b1, bus_tx_pin);
		cpu_stop <= 1'b0;
		$display("test stop done");
		wr(12'h000, 32'h24);
		cpu_wait <= 1'b1;
		repeat (2) @(posedge pclk);
		repeat (4) pin("tx wait", 1'b1, bus_tx_pin);
		// freeze with the pin forced; a running block would follow engine_tx again
		clk_en <= 1'b0;
		cpu_wait <= 1'b0;
		repeat (4) pin("tx frozen", 1'b1, bus_tx_pin);
		clk_en <= 1'b1;
		$display("test wait_freeze done");
		print_verdict;
	end
endmodule
